// file: hw/ulr_regs.sv
`timescale 1ns/1ps
`include "ulr_defs.svh"
module ulr_regs import ulr_pkg::*; (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Register strobes and data
	input wire logic [15:0] link_reg_re_i,
	input wire logic [15:0] link_reg_we_i,
	input wire logic [15:0] prot_reg_re_i,
	input wire logic [15:0] prot_reg_we_i,
	input wire logic [31:0] reg_write_data_i,
	output logic [31:0] reg_read_data_o,
	// Link engine status
	input wire logic [4:0] link_state_i,
	input wire logic [6:0] recovery_reason_i,
	input wire logic [8:0] interrupt_cause_set_i,
	input wire logic link_in_u1_i,
	input wire logic partner_power_req_i,
	input wire logic bus_power_absent_i,
	input wire logic [1:0] external_ctrl_hi_i,
	// Link engine control
	output logic link_enable_o,
	output logic scrambler_off_o,
	output logic power_req_grant_o,
	output logic [3:0] external_ctrl_out_o,
	output logic u2_timeout_o,
	output logic cmd_receiver_detect_o,
	output logic cmd_enter_recovery_o,
	output logic cmd_warm_reset_o,
	output logic cmd_power_request_o,
	output logic [1:0] power_level_select_o,
	output logic cmd_return_active_o,
	// Protocol layer
	input wire logic [31:0] endpoint_irq_i,
	output logic cmd_arbiter_reset_o,
	input wire logic [27:0] dma_addr_low_i,
	output logic [31:0] dma_address_o,
	// Interrupt
	output logic core_interrupt_out_o
);
	// Lowest strobe line wins if software raises several
	function automatic logic [4:0] strobe_pick(input logic [15:0] s);
		strobe_pick = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (s[i]) begin
				strobe_pick = {1'b1, 4'(i)};
			end
		end
	endfunction

	logic [4:0] lrd;
	logic [4:0] lwr;
	logic [4:0] prd;
	logic [4:0] pwr;
	logic lcfg_wr;
	logic lcmd_wr;
	logic lirq_wr;
	logic lstat_wr;
	logic pcfg_wr;
	logic pcmd_wr;
	logic pien_wr;
	logic dma_wr;
	ulr_word_t wd;
	ulr_word_t lcfg_q;
	ulr_word_t pcfg_q;
	ulr_word_t pien_q;
	ulr_word_t ppend_q;
	ulr_word_t rdata_q;
	ulr_word_t link_rd;
	ulr_word_t prot_rd;
	ulr_rsel_e rsel;
	logic link_irq_en_q;
	logic [8:0] cause_q;
	logic [8:0] cause_d;
	logic [6:0] reason_q;
	logic link_pend;
	logic power_gone;
	logic [1:0] ext_hi_q;
	logic [1:0] plvl_q;
	logic rxdet_q;
	logic recov_q;
	logic warm_q;
	logic preq_q;
	logic ret_q;
	logic arb_q;
	logic grant_q;
	logic irq_q;
	logic [31:0] dma_q;
	logic [15:0] pre_q;
	logic [7:0] u2cnt_q;
	logic u2_fired_q;
	logic u2_to_q;

	assign wd = reg_write_data_i;
	assign lrd = strobe_pick(link_reg_re_i);
	assign lwr = strobe_pick(link_reg_we_i);
	assign prd = strobe_pick(prot_reg_re_i);
	assign pwr = strobe_pick(prot_reg_we_i);
	assign lcfg_wr = lwr[4] && lwr[3:0] == `ULR_LCFG;
	assign lcmd_wr = lwr[4] && lwr[3:0] == `ULR_LCMD;
	assign lirq_wr = lwr[4] && lwr[3:0] == `ULR_LIRQ;
	assign lstat_wr = lwr[4] && lwr[3:0] == `ULR_LSTAT;
	assign pcfg_wr = pwr[4] && pwr[3:0] == `ULR_PCFG;
	assign pcmd_wr = pwr[4] && pwr[3:0] == `ULR_PCMD;
	assign pien_wr = pwr[4] && pwr[3:0] == `ULR_PIEN;
	assign dma_wr = pwr[4] && pwr[3:0] == `ULR_DMA;

	ulr_sync u_vbus (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.async_i(bus_power_absent_i),
		.sync_o(power_gone)
	);

	// Configuration registers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			lcfg_q <= `ULR_RST_WORD;
			pcfg_q <= `ULR_RST_WORD;
			pien_q <= `ULR_RST_WORD;
			link_irq_en_q <= 1'b0;
			dma_q <= `ULR_RST_WORD;
		end else if (ce_i) begin
			if (lcfg_wr) begin
				lcfg_q <= wd & `ULR_LCFG_MASK;
			end
			if (lirq_wr) begin
				link_irq_en_q <= wd[`ULR_LIRQ_EN];
			end
			if (pcfg_wr) begin
				pcfg_q <= wd;
			end
			if (pien_wr) begin
				pien_q <= wd & `ULR_PIRQ_MASK;
			end
			if (dma_wr) begin
				dma_q[`ULR_DMA_BASE] <= wd[`ULR_DMA_BASE];
			end
			// Low address bits follow the engine each cycle
			dma_q[27:0] <= dma_addr_low_i;
		end
	end

	// Command pulses last one cycle, only the power level is kept
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rxdet_q <= 1'b0;
			recov_q <= 1'b0;
			warm_q <= 1'b0;
			preq_q <= 1'b0;
			ret_q <= 1'b0;
			arb_q <= 1'b0;
			plvl_q <= 2'h0;
		end else if (ce_i) begin
			// No start while the link is disabled
			rxdet_q <= lcmd_wr && wd[`ULR_CMD_RXDET] &&
				lcfg_q[`ULR_LCFG_EN];
			recov_q <= lcmd_wr && wd[`ULR_CMD_RECOV];
			warm_q <= lcmd_wr && wd[`ULR_CMD_WARM];
			preq_q <= lcmd_wr && wd[`ULR_CMD_PREQ];
			ret_q <= lcmd_wr && wd[`ULR_CMD_RET];
			arb_q <= pcmd_wr && wd[`ULR_CMD_ARB];
			if (lcmd_wr && wd[`ULR_CMD_PREQ]) begin
				plvl_q <= wd[`ULR_CMD_PLVL];
			end
		end
	end

	// Partner power requests pass only when accepted
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			grant_q <= 1'b0;
			ext_hi_q <= 2'h0;
		end else if (ce_i) begin
			grant_q <= partner_power_req_i &&
				lcfg_q[`ULR_LCFG_PACC];
			ext_hi_q <= external_ctrl_hi_i;
		end
	end

	// Set wins over a clearing write in the same cycle
	always_comb begin
		cause_d = cause_q;
		if (lstat_wr) begin
			cause_d = cause_q & ~wd[`ULR_CAUSE];
		end
		cause_d = cause_d | interrupt_cause_set_i;
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cause_q <= 9'h000;
			reason_q <= 7'h00;
		end else if (ce_i) begin
			cause_q <= cause_d;
			// Reason frozen while bit 7 stays set
			if (interrupt_cause_set_i[0] && !cause_q[0]) begin
				reason_q <= recovery_reason_i;
			end
		end
	end

	assign link_pend = |cause_q;

	// Pending endpoint requests are levels from the engines
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ppend_q <= `ULR_RST_WORD;
		end else if (ce_i) begin
			ppend_q <= endpoint_irq_i & `ULR_PIRQ_MASK;
		end
	end

	// Level interrupt, one cycle behind the flags
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			irq_q <= 1'b0;
		end else if (ce_i) begin
			irq_q <= (link_pend && link_irq_en_q) ||
				(|(ppend_q & pien_q));
		end
	end

	// U1 to U2 timer, field zero disables it
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pre_q <= 16'h0000;
			u2cnt_q <= 8'h00;
			u2_fired_q <= 1'b0;
			u2_to_q <= 1'b0;
		end else if (ce_i) begin
			u2_to_q <= 1'b0;
			if (!link_in_u1_i || lcfg_q[`ULR_LCFG_U2] == 8'h00) begin
				pre_q <= 16'h0000;
				u2cnt_q <= 8'h00;
				u2_fired_q <= 1'b0;
			end else if (u2cnt_q == lcfg_q[`ULR_LCFG_U2]) begin
				u2_to_q <= !u2_fired_q;
				u2_fired_q <= 1'b1;
			end else begin
				pre_q <= pre_q + 16'h0001;
				if (pre_q == `ULR_U2_PRE_MAX) begin
					u2cnt_q <= u2cnt_q + 8'h01;
				end
			end
		end
	end

	// Read muxes; command registers read zero
	always_comb begin
		link_rd = `ULR_RST_WORD;
		unique case (lrd[3:0])
			`ULR_LCFG: link_rd = lcfg_q;
			`ULR_LIRQ: link_rd = {30'h0, link_irq_en_q, link_pend};
			`ULR_LSTAT: link_rd = {power_gone, 2'h0, link_state_i, 8'h00,
				cause_q, reason_q};
			default: link_rd = `ULR_RST_WORD;
		endcase
	end

	always_comb begin
		prot_rd = `ULR_RST_WORD;
		unique case (prd[3:0])
			`ULR_PCFG: prot_rd = pcfg_q;
			`ULR_PIEN: prot_rd = pien_q;
			`ULR_PIRQ: prot_rd = ppend_q;
			`ULR_DMA: prot_rd = {dma_q[`ULR_DMA_BASE], 28'h0};
			default: prot_rd = `ULR_RST_WORD;
		endcase
	end

	always_comb begin
		rsel = RD_NONE;
		if (lrd[4]) begin
			rsel = RD_LINK;
		end else if (prd[4]) begin
			rsel = RD_PROT;
		end
	end

	// Data holds until the next read strobe
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_q <= `ULR_RST_WORD;
		end else if (ce_i) begin
			unique case (rsel)
				RD_LINK: rdata_q <= link_rd;
				RD_PROT: rdata_q <= prot_rd;
				RD_NONE: rdata_q <= rdata_q;
			endcase
		end
	end

	assign reg_read_data_o = rdata_q;
	assign link_enable_o = lcfg_q[`ULR_LCFG_EN];
	assign scrambler_off_o = lcfg_q[`ULR_LCFG_SCR];
	assign power_req_grant_o = grant_q;
	assign external_ctrl_out_o = {ext_hi_q, lcfg_q[`ULR_LCFG_EXT]};
	assign u2_timeout_o = u2_to_q;
	assign cmd_receiver_detect_o = rxdet_q;
	assign cmd_enter_recovery_o = recov_q;
	assign cmd_warm_reset_o = warm_q;
	assign cmd_power_request_o = preq_q;
	assign power_level_select_o = plvl_q;
	assign cmd_return_active_o = ret_q;
	assign cmd_arbiter_reset_o = arb_q;
	assign dma_address_o = dma_q;
	assign core_interrupt_out_o = irq_q;

	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	warm_pulse_a: assert property (
		ce_i && cmd_warm_reset_o |=> !cmd_warm_reset_o)
		else $error("warm reset command held past one cycle");

	rxdet_gate_a: assert property (
		ce_i && lcmd_wr && !lcfg_q[`ULR_LCFG_EN] |=>
		!cmd_receiver_detect_o)
		else $error("receiver detect issued while link disabled");

	link_irq_a: assert property (
		ce_i && link_pend && link_irq_en_q |=> core_interrupt_out_o)
		else $error("link interrupt not raised");

	prot_irq_a: assert property (
		ce_i && |(ppend_q & pien_q) |=> core_interrupt_out_o)
		else $error("protocol interrupt not raised");

	cause_set_a: assert property (
		ce_i && |interrupt_cause_set_i |=> link_pend)
		else $error("cause event lost");

	reason_hold_a: assert property (
		ce_i && cause_q[0] |=> reason_q == $past(reason_q))
		else $error("recovery reason changed while held");

	cmd_read_a: assert property (
		ce_i && lrd == {1'b1, `ULR_LCMD} |=> reg_read_data_o == 32'h0)
		else $error("command register read nonzero");

	ext_ctrl_a: assert property (
		ce_i && lcfg_wr |=>
		external_ctrl_out_o[1:0] == $past(reg_write_data_i[5:4]))
		else $error("external control not following config");

	u2_pulse_a: assert property (
		ce_i && u2_timeout_o |=> !u2_timeout_o)
		else $error("u2 timeout longer than one cycle");

	grant_gate_a: assert property (
		ce_i && !lcfg_q[`ULR_LCFG_PACC] |=> !power_req_grant_o)
		else $error("power request granted while not accepted");
endmodule

// file: hw/ulr_defs.svh
// Function
// - Link enable allows state machine transitions
// - Accept partner power requests only when enabled
// - Scrambler-off bit disables link scrambling
// - Config field drives external control bits 1:0
// - U2 inactivity count times 0x10000 clocks
// - Receiver detect needs link enable first
// - Command bits request recovery or warm reset
// - Power level field selects U1, U2, U3
// - Power request attempts selected low-power entry
// - Return-active command brings link to U0
// - Pending flag with enable raises interrupt
// - Recovery reason held while status bit 7
// - Cause bits set pending, clear on one
// - Status shows current link state code
// - Status top bit shows bus power absent
// - Protocol command bit 0 resets arbiter
// - Protocol interrupt enables per endpoint source
// - Pending and matching enable raise interrupt
// - DMA base supplies address bits 31:28
// - Read data valid cycle after strobe
// - Interrupt output is a level
`ifndef ULR_DEFS_SVH
`define ULR_DEFS_SVH

`define ULR_LCFG 4'h0
`define ULR_LCMD 4'h1
`define ULR_LIRQ 4'h2
`define ULR_LSTAT 4'h3
`define ULR_PCFG 4'h0
`define ULR_PCMD 4'h1
`define ULR_PIEN 4'h2
`define ULR_PIRQ 4'h3
`define ULR_DMA 4'h4

`define ULR_LCFG_EN 0
`define ULR_LCFG_PACC 1
`define ULR_LCFG_SCR 2
`define ULR_LCFG_EXT 5:4
`define ULR_LCFG_U2 15:8
`define ULR_LCFG_MASK 32'h0000FF37

`define ULR_CMD_RXDET 0
`define ULR_CMD_RECOV 3
`define ULR_CMD_WARM 7
`define ULR_CMD_PLVL 9:8
`define ULR_CMD_PREQ 10
`define ULR_CMD_RET 11
`define ULR_CMD_ARB 0

`define ULR_LIRQ_PEND 0
`define ULR_LIRQ_EN 1
`define ULR_CAUSE 15:7
`define ULR_PIRQ_MASK 32'h00FF00FF
`define ULR_DMA_BASE 31:28

`define ULR_RST_WORD 32'h00000000
`define ULR_U2_PRE_MAX 16'hFFFF

`endif

// file: hw/ulr_pkg.sv
package ulr_pkg;
	typedef logic [31:0] ulr_word_t;
	typedef enum logic [1:0] {RD_NONE, RD_LINK, RD_PROT} ulr_rsel_e;
endpackage

// file: hw/ulr_sync.sv
`timescale 1ns/1ps
module ulr_sync (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Asynchronous level in, synchronous level out
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic sync_q;

	// First stage feeds only the second
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (ce_i) begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// file: tb/ulr_host.sv
`timescale 1ns/1ps
module ulr_host (
	// Clock and read data
	input wire logic clock_i,
	input wire logic [31:0] rd_i,
	// Strobes and write data
	output logic [15:0] lre_o,
	output logic [15:0] pre_o,
	output logic [15:0] lwe_o,
	output logic [15:0] pwe_o,
	output logic [31:0] wd_o
);
	initial begin
		{pwe_o, lwe_o, pre_o, lre_o} = '0;
		wd_o = '0;
	end
	// One strobe line per access, never two commands in one word
	task automatic acc(input bit w, input bit p, input int i,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		#1;
		wd_o = w ? d : ~d;
		{pwe_o, lwe_o, pre_o, lre_o} = 64'h1 << (i + 16 * (2 * w + p));
		@(posedge clock_i);
		#1;
		q = rd_i;
		{pwe_o, lwe_o, pre_o, lre_o} = '0;
		// Released bus does not keep old data
		wd_o = ~wd_o;
	endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clock_i = 0;
	logic reset_i = 1;
	logic ce_i = 1;
	logic link_in_u1_i = 0;
	logic partner_power_req_i = 0;
	logic bus_power_absent_i = 0;
	logic [4:0] link_state_i = 0;
	logic [6:0] recovery_reason_i = 0;
	logic [8:0] interrupt_cause_set_i = 0;
	logic [1:0] external_ctrl_hi_i = 2'h2;
	logic [31:0] endpoint_irq_i = 0;
	logic [27:0] dma_addr_low_i = 0;
	logic [15:0] link_reg_re_i, link_reg_we_i, prot_reg_re_i, prot_reg_we_i;
	logic [31:0] reg_write_data_i, reg_read_data_o, dma_address_o, q;
	logic link_enable_o, scrambler_off_o, power_req_grant_o, u2_timeout_o;
	logic cmd_receiver_detect_o, cmd_enter_recovery_o, cmd_warm_reset_o;
	logic cmd_power_request_o, cmd_return_active_o, cmd_arbiter_reset_o;
	logic core_interrupt_out_o;
	logic [1:0] power_level_select_o;
	logic [3:0] external_ctrl_out_o;
	logic [5:0] cmds;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;

	assign cmds = {cmd_receiver_detect_o, cmd_enter_recovery_o,
		cmd_warm_reset_o, cmd_power_request_o, cmd_return_active_o,
		cmd_arbiter_reset_o};

	ulr_regs i_dut (.clock_i, .reset_i, .ce_i, .link_reg_re_i, .link_reg_we_i,
		.prot_reg_re_i, .prot_reg_we_i, .reg_write_data_i, .reg_read_data_o,
		.link_state_i, .recovery_reason_i, .interrupt_cause_set_i,
		.link_in_u1_i, .partner_power_req_i, .bus_power_absent_i,
		.external_ctrl_hi_i, .link_enable_o, .scrambler_off_o,
		.power_req_grant_o, .external_ctrl_out_o, .u2_timeout_o,
		.cmd_receiver_detect_o, .cmd_enter_recovery_o, .cmd_warm_reset_o,
		.cmd_power_request_o, .power_level_select_o, .cmd_return_active_o,
		.endpoint_irq_i, .cmd_arbiter_reset_o, .dma_addr_low_i,
		.dma_address_o, .core_interrupt_out_o);

	ulr_host i_host (.clock_i(clock_i), .rd_i(reg_read_data_o),
		.lre_o(link_reg_re_i), .pre_o(prot_reg_re_i), .lwe_o(link_reg_we_i),
		.pwe_o(prot_reg_we_i), .wd_o(reg_write_data_i));

	initial begin
		forever #20 clock_i = ~clock_i;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task wr(input bit p, input int i, input logic [31:0] d);
		i_host.acc(1, p, i, d, q);
	endtask
	task rd(input bit p, input int i, input logic [31:0] m, e);
		i_host.acc(0, p, i, 0, q);
		chk(q & m, e);
	endtask

	task t_cfg;
		wr(0, 0, 32'hFFFFFFFF);
		rd(0, 0, 32'hFFFFFFFF, 32'h0000FF37);
		chk({scrambler_off_o, link_enable_o, external_ctrl_out_o}, 6'h3B);
		partner_power_req_i = 1;
		tick(1);
		partner_power_req_i = 0;
		chk(power_req_grant_o, 1);
		wr(0, 0, 0);
		partner_power_req_i = 1;
		tick(1);
		partner_power_req_i = 0;
		chk(power_req_grant_o, 0);
		chk({scrambler_off_o, link_enable_o, external_ctrl_out_o}, 6'h08);
		$display("test cfg done");
	endtask

	task t_cmd;
		logic [31:0] d[6];
		d = '{32'h1, 32'h8, 32'h80, 32'h600, 32'h800, 32'h1};
		wr(0, 0, 1);
		for (int k = 0; k < 6; k++) begin
			wr(k == 5, 1, d[k]);
			chk(cmds, 6'h20 >> k);
			tick(1);
			chk(cmds, 0);
		end
		for (int l = 1; l < 4; l++) begin
			wr(0, 1, 32'h400 | (l << 8));
			chk(power_level_select_o, l);
		end
		wr(0, 0, 0);
		wr(0, 1, 1);
		chk(cmds, 0);
		rd(0, 1, '1, 0);
		rd(1, 1, '1, 0);
		rd(0, 9, '1, 0);
		$display("test cmd done");
	endtask

	task t_lirq;
		wr(0, 2, 2);
		recovery_reason_i = 7'h55;
		interrupt_cause_set_i = 9'h1;
		tick(1);
		interrupt_cause_set_i = 0;
		recovery_reason_i = 7'h2A;
		tick(1);
		chk(core_interrupt_out_o, 1);
		rd(0, 3, 32'hFF, 32'hD5);
		rd(0, 2, 3, 3);
		wr(0, 3, 32'h80);
		tick(2);
		chk(core_interrupt_out_o, 0);
		wr(0, 2, 0);
		interrupt_cause_set_i = 9'h2;
		tick(1);
		interrupt_cause_set_i = 0;
		tick(2);
		chk(core_interrupt_out_o, 0);
		rd(0, 2, 3, 1);
		wr(0, 3, 32'h100);
		tick(2);
		rd(0, 2, 3, 0);
		$display("test link irq done");
	endtask

	task t_pirq;
		wr(1, 2, '1);
		rd(1, 2, '1, 32'h00FF00FF);
		wr(1, 2, 32'h10000);
		endpoint_irq_i = 32'h1;
		tick(3);
		chk(core_interrupt_out_o, 0);
		rd(1, 3, '1, 1);
		endpoint_irq_i = 32'h10001;
		tick(3);
		chk(core_interrupt_out_o, 1);
		endpoint_irq_i = 0;
		tick(3);
		chk(core_interrupt_out_o, 0);
		$display("test prot irq done");
	endtask

	task t_stat;
		link_state_i = 5'h1A;
		bus_power_absent_i = 1;
		tick(4);
		rd(0, 3, 32'hFF000000, 32'h9A000000);
		bus_power_absent_i = 0;
		tick(4);
		rd(0, 3, 32'hFF000000, 32'h1A000000);
		$display("test status done");
	endtask

	task t_dma;
		wr(1, 4, 32'hA5A5A5A5);
		rd(1, 4, '1, 32'hA0000000);
		dma_addr_low_i = 28'h1234567;
		tick(3);
		chk(dma_address_o, 32'hA1234567);
		// Enable low must freeze the address register
		ce_i = 0;
		dma_addr_low_i = 28'h7654321;
		tick(3);
		chk(dma_address_o, 32'hA1234567);
		ce_i = 1;
		tick(1);
		chk(dma_address_o, 32'hA7654321);
		$display("test dma done");
	endtask

	// Field 1 gives one prescaler turn, pulse one edge later
	task t_u2;
		wr(0, 0, 32'h100);
		link_in_u1_i = 1;
		tick(65536);
		chk(u2_timeout_o, 0);
		tick(1);
		chk(u2_timeout_o, 1);
		tick(1);
		chk(u2_timeout_o, 0);
		link_in_u1_i = 0;
		$display("test u2 timer done");
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Ceiling some 4300 cycles above the U2 wait plus the other tests
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 70000) begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			end_sim;
		end
	end

	initial begin
		tick(2);
		reset_i = 0;
		t_cfg;
		t_cmd;
		t_lirq;
		t_pirq;
		t_stat;
		t_dma;
		t_u2;
		end_sim;
	end
endmodule
